// [rtl/csrc_pkg.sv]
package csrc_pkg;

  // Bus geometry
  localparam int APB_AW = 12;
  localparam int IDX_W = 10;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PLL_CTL = 10'h010;
  localparam logic [IDX_W-1:0] IDX_VCO_CAL = 10'h018;
  localparam logic [IDX_W-1:0] IDX_DIV_RATIO = 10'h1e0;
  localparam logic [IDX_W-1:0] IDX_ROUTING = 10'h1e1;
  localparam logic [IDX_W-1:0] IDX_UPDATE = 10'h232;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h233;

  // Field widths
  localparam int PLL_CTL_W = 8;
  localparam int CAL_W = 1;
  localparam int DIV_W = 3;
  localparam int ROUTE_W = 2;

  // Reset values
  localparam logic [PLL_CTL_W-1:0] RST_PLL_CTL = 8'h01;
  localparam logic [CAL_W-1:0] RST_VCO_CAL = 1'h0;
  localparam logic [DIV_W-1:0] RST_DIV_RATIO = 3'h2;
  localparam logic [ROUTE_W-1:0] RST_ROUTING = 2'h0;

  // Field positions
  localparam int PWR_LSB = 0;
  localparam int PWR_MSB = 1;
  localparam int PFD_BIT = 7;
  localparam int CAL_BIT = 0;
  localparam int BYP_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int UPD_BIT = 0;

  // Status register layout
  localparam int ST_PWR_LSB = 0;
  localparam int ST_PWR_MSB = 1;
  localparam int ST_BYP_BIT = 2;
  localparam int ST_SRC_BIT = 3;
  localparam int ST_DIV_LSB = 4;
  localparam int ST_DIV_MSB = 6;
  localparam int ST_BUSY_BIT = 7;

  // PLL power codes
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ASYNC_PD = 2'h1;

  // Divider codes: ratio is code plus base, top code divides by six
  localparam logic [DIV_W-1:0] DIV_BASE = 3'h2;
  localparam logic [DIV_W-1:0] DIV_CODE_MAX = 3'h4;

  // Calibration length in divider output ticks
  localparam int CAL_TICKS_DEF = 32;

  typedef struct packed {
    logic [PLL_CTL_W-1:0] pllCtl;
    logic [CAL_W-1:0] calReq;
    logic [DIV_W-1:0] divCode;
    logic [ROUTE_W-1:0] routing;
  } csrc_cfg_s;

  typedef struct packed {
    logic pllPowerDown;
    logic pllRunning;
    logic pfdNegative;
    logic vcoPowered;
    logic prescalerFromExt;
    logic divInPath;
  } csrc_route_s;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } csrc_cal_e;

endpackage

// [rtl/csrc_stage_reg.sv]
`timescale 1ns/1ns
module csrc_stage_reg
  import csrc_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Staging write
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  // Transfer to active copy
  input wire logic update,
  // Copies
  output logic [W-1:0] staged,
  output logic [W-1:0] active
);

  if (W < 1) begin : g_chk
    $error("csrc_stage_reg width must be at least one");
  end

  // Staged copy
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      staged <= RST;
    end else if (wrEn) begin
      staged <= wrData;
    end
  end

  // Active copy loads only on update
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      active <= RST;
    end else if (update) begin
      active <= staged;
    end
  end

endmodule

// [rtl/csrc_vco_div.sv]
`timescale 1ns/1ns
module csrc_vco_div
  import csrc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Source edges and ratio code
  input wire logic tickIn,
  input wire logic [DIV_W-1:0] divCode,
  // Divided edges
  output logic tickOut
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] code;
  logic [DIV_W-1:0] last;

  // Codes above the top code divide by six, never below two
  always_comb begin
    code = (divCode > DIV_CODE_MAX) ? DIV_CODE_MAX : divCode;
    last = DIV_W'(code + DIV_BASE - 3'h1);
  end

  // Count source edges
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (tickIn) begin
      cnt_q <= (cnt_q >= last) ? '0 : DIV_W'(cnt_q + 3'h1);
    end
  end

  // One output edge per ratio source edges
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tickOut <= 1'b0;
    end else begin
      tickOut <= tickIn && (cnt_q >= last);
    end
  end

endmodule

// [rtl/csrc_top.sv]
// What this block does
// - After reset PLL is off and input clock reaches distribution via divider.
// - Power field 01 puts PLL in power-down, 00 runs it; default 01.
// - Divider ratio field defaults to code 010, divide by four.
// - Divider offers ratios two to six chosen by the ratio field.
// - Bypass bit 0 feeds distribution from the divider output; default.
// - Bypass bit 1 feeds the selected source straight to distribution.
// - Source bit 0 selects external input, 1 selects internal oscillator.
// - Settings take effect only when the update register receives a write with bit 0 set.
// - Polarity bit 0 means positive detector polarity, 1 negative.
// - Reset restores power, ratio, bypass and source fields to defaults.
// - PLL on with external input selected powers off internal oscillator.
// - Divider path always divides by at least two.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module csrc_top
  import csrc_pkg::*;
#(
  parameter int CAL_TICKS = CAL_TICKS_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock source edges as enables
  input wire logic extClkTick,
  input wire logic vcoTick,
  // Routing and control outputs
  output csrc_route_s routeCtl,
  output logic distTick,
  output logic calStart,
  output logic calBusy
);

  if (CAL_TICKS < 1 || CAL_TICKS > 65535) begin : g_chk
    $error("csrc_top CAL_TICKS out of range");
  end

  csrc_cfg_s staged;
  csrc_cfg_s active;
  csrc_cal_e calState_q;
  logic [15:0] calCnt_q;
  logic calReqPrev_q;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic hitPll;
  logic hitCal;
  logic hitDiv;
  logic hitRoute;
  logic hitUpd;
  logic hitStat;
  logic mapped;
  logic [7:0] rdMux;
  logic [7:0] statusByte;
  logic wrAcc;
  logic updPulse;
  logic srcTick;
  logic divTick;
  logic calRise;

  // Address decode
  always_comb begin
    idx = paddr[APB_AW-1:2];
    aligned = (paddr[1:0] == 2'h0);
    hitPll = 1'b0;
    hitCal = 1'b0;
    hitDiv = 1'b0;
    hitRoute = 1'b0;
    hitUpd = 1'b0;
    hitStat = 1'b0;
    if (!aligned) begin
      hitPll = 1'b0;
    end else if (idx == IDX_PLL_CTL) begin
      hitPll = 1'b1;
    end else if (idx == IDX_VCO_CAL) begin
      hitCal = 1'b1;
    end else if (idx == IDX_DIV_RATIO) begin
      hitDiv = 1'b1;
    end else if (idx == IDX_ROUTING) begin
      hitRoute = 1'b1;
    end else if (idx == IDX_UPDATE) begin
      hitUpd = 1'b1;
    end else if (idx == IDX_STATUS) begin
      hitStat = 1'b1;
    end
    mapped = hitPll | hitCal | hitDiv | hitRoute | hitUpd | hitStat;
  end

  // Status shows the active configuration and calibration state
  always_comb begin
    statusByte = '0;
    statusByte[ST_PWR_MSB:ST_PWR_LSB] = active.pllCtl[PWR_MSB:PWR_LSB];
    statusByte[ST_BYP_BIT] = active.routing[BYP_BIT];
    statusByte[ST_SRC_BIT] = active.routing[SRC_BIT];
    statusByte[ST_DIV_MSB:ST_DIV_LSB] = active.divCode;
    statusByte[ST_BUSY_BIT] = (calState_q == CAL_RUN);
  end

  // Read data mux, register reads return staged values, status reads the active copy
  always_comb begin
    rdMux = '0;
    if (hitPll) begin
      rdMux = staged.pllCtl;
    end else if (hitCal) begin
      rdMux[CAL_BIT] = staged.calReq[0];
    end else if (hitDiv) begin
      rdMux[DIV_W-1:0] = staged.divCode;
    end else if (hitRoute) begin
      rdMux[ROUTE_W-1:0] = staged.routing;
    end else if (hitStat) begin
      rdMux = statusByte;
    end
  end

  // Access phase completes one cycle after setup
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Response data and error latched at setup
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= (!pwrite && mapped) ? {24'h0, rdMux} : '0;
      pslverr <= !mapped;
    end
  end

  // Writes take effect at the completing access edge
  always_comb begin
    wrAcc = psel && penable && pready && pwrite && mapped && pstrb[0];
  end

  always_comb begin
    updPulse = wrAcc && hitUpd && pwdata[UPD_BIT];
  end

  csrc_stage_reg #(
    .W(PLL_CTL_W),
    .RST(RST_PLL_CTL)
  ) u_pll_ctl (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(wrAcc && hitPll),
    .wrData(pwdata[PLL_CTL_W-1:0]),
    .update(updPulse),
    .staged(staged.pllCtl),
    .active(active.pllCtl)
  );

  csrc_stage_reg #(
    .W(CAL_W),
    .RST(RST_VCO_CAL)
  ) u_vco_cal (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(wrAcc && hitCal),
    .wrData(pwdata[CAL_BIT]),
    .update(updPulse),
    .staged(staged.calReq),
    .active(active.calReq)
  );

  csrc_stage_reg #(
    .W(DIV_W),
    .RST(RST_DIV_RATIO)
  ) u_div_ratio (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(wrAcc && hitDiv),
    .wrData(pwdata[DIV_W-1:0]),
    .update(updPulse),
    .staged(staged.divCode),
    .active(active.divCode)
  );

  csrc_stage_reg #(
    .W(ROUTE_W),
    .RST(RST_ROUTING)
  ) u_routing (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(wrAcc && hitRoute),
    .wrData(pwdata[ROUTE_W-1:0]),
    .update(updPulse),
    .staged(staged.routing),
    .active(active.routing)
  );

  always_comb begin
    srcTick = active.routing[SRC_BIT] ? vcoTick : extClkTick;
  end

  csrc_vco_div u_vco_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tickIn(srcTick),
    .divCode(active.divCode),
    .tickOut(divTick)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      distTick <= 1'b0;
    end else begin
      distTick <= active.routing[BYP_BIT] ? srcTick : divTick;
    end
  end

  // Routing controls from active copy
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      routeCtl <= '0;
    end else begin
      routeCtl.pllPowerDown <= active.pllCtl[PWR_MSB:PWR_LSB] != PWR_NORMAL;
      routeCtl.pllRunning <= active.pllCtl[PWR_MSB:PWR_LSB] == PWR_NORMAL;
      routeCtl.pfdNegative <= active.pllCtl[PFD_BIT];
      routeCtl.vcoPowered <= (active.pllCtl[PWR_MSB:PWR_LSB] == PWR_NORMAL)
        && active.routing[SRC_BIT];
      routeCtl.prescalerFromExt <=
        (active.pllCtl[PWR_MSB:PWR_LSB] == PWR_NORMAL)
        && !active.routing[SRC_BIT];
      routeCtl.divInPath <= !active.routing[BYP_BIT];
    end
  end

  // Previous active calibration bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      calReqPrev_q <= 1'b0;
    end else begin
      calReqPrev_q <= active.calReq[0];
    end
  end

  // only a fresh rising request starts a run, and only from idle
  always_comb begin
    calRise = active.calReq[0] && !calReqPrev_q;
  end

  // Calibration sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      calState_q <= CAL_IDLE;
      calCnt_q <= '0;
    end else begin
      case (calState_q)
        CAL_IDLE: begin
          if (calRise) begin
            calState_q <= CAL_RUN;
            calCnt_q <= '0;
          end
        end
        CAL_RUN: begin
          if (divTick) begin
            if (calCnt_q == 16'(CAL_TICKS - 1)) begin
              calState_q <= CAL_IDLE;
            end
            calCnt_q <= 16'(calCnt_q + 16'h1);
          end
        end
        default: begin
          calState_q <= CAL_IDLE;
        end
      endcase
    end
  end

  // Calibration outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      calStart <= 1'b0;
      calBusy <= 1'b0;
    end else begin
      calStart <= (calState_q == CAL_IDLE) && calRise;
      calBusy <= (calState_q == CAL_RUN)
        || ((calState_q == CAL_IDLE) && calRise);
    end
  end

endmodule

// [dv/csrc_monitor.sv]
`timescale 1ns/1ns
module csrc_monitor
  import csrc_pkg::*;
#(
  parameter int CAL_TICKS = CAL_TICKS_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Clock path
  input wire logic extClkTick,
  input wire logic vcoTick,
  input wire csrc_route_s routeCtl,
  input wire logic distTick,
  input wire logic calStart,
  input wire logic calBusy
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [1:0] age_q;
  logic updWr;
  logic mapped;
  assign updWr = psel && penable && pready && pwrite && pstrb[0]
    && pwdata[0] && paddr == {IDX_UPDATE, 2'b00};
  assign mapped = paddr inside {{IDX_PLL_CTL, 2'b00}, {IDX_VCO_CAL, 2'b00},
    {IDX_DIV_RATIO, 2'b00}, {IDX_ROUTING, 2'b00}, {IDX_UPDATE, 2'b00},
    {IDX_STATUS, 2'b00}};
  // Cycles since reset, saturating
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  upd_only_a: assert property (
    age_q == 2'h3 && $changed(routeCtl) |-> $past(updWr) || $past(updWr, 2))
    else $error("routing changed without update write");
  rst_dflt_a: assert property (
    age_q == 2'h2 |-> routeCtl == 6'h21)
    else $error("routing not at defaults after reset");
  pwr_state_a: assert property (
    age_q == 2'h3 |-> routeCtl.pllRunning != routeCtl.pllPowerDown)
    else $error("power state inconsistent");
  ext_vco_a: assert property (
    routeCtl.prescalerFromExt |-> routeCtl.pllRunning && !routeCtl.vcoPowered)
    else $error("oscillator powered with external prescaler feed");
  min_div_a: assert property (
    distTick && routeCtl.divInPath && $past(routeCtl.divInPath)
    && $past(routeCtl.divInPath, 2) |=> !distTick || !routeCtl.divInPath)
    else $error("divider path ticks back to back");
  cal_start_a: assert property (
    calStart |-> calBusy && ($past(updWr) || $past(updWr, 2)) ##1 !calStart)
    else $error("calibration start without update");
  cal_rise_a: assert property (
    $rose(calBusy) |-> calStart)
    else $error("busy rose without start pulse");
  apb_tim_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("access cycle timing wrong");
  bad_addr_a: assert property (
    pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  cover property (calStart);
  cover property (distTick && !routeCtl.divInPath);
  cover property (pready && pslverr);
endmodule

bind csrc_top csrc_monitor #(.CAL_TICKS(CAL_TICKS)) mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .extClkTick(extClkTick), .vcoTick(vcoTick), .routeCtl(routeCtl),
  .distTick(distTick), .calStart(calStart), .calBusy(calBusy)
);

// [dv/tb_top.sv]
`timescale 1ns/1ns
module tb_top
  import csrc_pkg::*;
;
  typedef struct packed {
    logic [7:0] pll;
    logic [2:0] div;
    logic [1:0] rt;
    logic [7:0] iv;
    logic [5:0] route;
  } csrc_row_s;
  localparam logic [APB_AW-1:0] A_PLL = {IDX_PLL_CTL, 2'b00};
  localparam logic [APB_AW-1:0] A_CAL = {IDX_VCO_CAL, 2'b00};
  localparam logic [APB_AW-1:0] A_DIV = {IDX_DIV_RATIO, 2'b00};
  localparam logic [APB_AW-1:0] A_RT = {IDX_ROUTING, 2'b00};
  localparam logic [APB_AW-1:0] A_UPD = {IDX_UPDATE, 2'b00};
  localparam logic [APB_AW-1:0] A_ST = {IDX_STATUS, 2'b00};
  logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, extClkTick = 1'b0, vcoTick = 1'b0, pready, pslverr;
  logic distTick, calStart, calBusy, er;
  logic [3:0] pstrb = 4'hf;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, iv, calCnt = '0;
  csrc_route_s routeCtl;
  int n_mismatch = 0, n_tests = 0;
  logic [5:0] pe = 6'h21;
  logic [APB_AW-1:0] ra [5] = '{A_PLL, A_CAL, A_DIV, A_RT, A_ST};
  logic [7:0] rv [5] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h21};
  // bypass rows use both sources, external input and oscillator
  // Ext ticks every cycle, oscillator every second cycle
  csrc_row_s rows [9] = '{
    '{8'h01, 3'h2, 2'h0, 8'h04, 6'h21}, '{8'h03, 3'h2, 2'h0, 8'h04, 6'h21},
    '{8'h00, 3'h0, 2'h0, 8'h02, 6'h13},
    '{8'h80, 3'h1, 2'h0, 8'h03, 6'h1b}, '{8'h00, 3'h3, 2'h2, 8'h0a, 6'h15},
    '{8'h00, 3'h4, 2'h2, 8'h0c, 6'h15}, '{8'h00, 3'h7, 2'h0, 8'h06, 6'h13},
    '{8'h00, 3'h0, 2'h1, 8'h01, 6'h12}, '{8'h00, 3'h0, 2'h3, 8'h02, 6'h14}};

  csrc_top #(.CAL_TICKS(2)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extClkTick(extClkTick), .vcoTick(vcoTick), .routeCtl(routeCtl),
    .distTick(distTick), .calStart(calStart), .calBusy(calBusy)
  );

  always #10 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    extClkTick <= !sys_rst;
    vcoTick <= !sys_rst && !vcoTick;
    if (calStart === 1'b1) begin
      calCnt <= calCnt + 32'h1;
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    @(posedge core_clk);
  endtask

  task automatic measure();
    int c;
    for (int k = 0; k < 3; k++) begin
      c = 0;
      do begin
        @(posedge core_clk);
        c++;
      end while (distTick !== 1'b1 && c < 40);
      if (c >= 40) begin
        n_mismatch++;
        print_verdict();
      end
    end
    iv = c;
  endtask

  task automatic rstChk();
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({26'h0, routeCtl}, 32'h21);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, ra[k], 32'h0);
      chk(rd, {24'h0, rv[k]});
    end
    $display("reset test done");
  endtask

  task automatic calTry(input logic v, input logic [31:0] e);
    logic [31:0] c0;
    c0 = calCnt;
    apb(1'b1, A_CAL, {31'h0, v});
    apb(1'b1, A_UPD, 32'h1);
    @(posedge core_clk);
    chk({31'h0, calBusy}, e);
    repeat (29) @(posedge core_clk);
    chk(calCnt - c0, e);
    chk({31'h0, calBusy}, 32'h0);
  endtask

  initial begin
    rstChk();
    foreach (rows[i]) begin
      apb(1'b1, A_PLL, {24'h0, rows[i].pll});
      apb(1'b1, A_DIV, {29'h0, rows[i].div});
      apb(1'b1, A_RT, {30'h0, rows[i].rt});
      chk({26'h0, routeCtl}, {26'h0, pe});
      apb(1'b1, A_UPD, 32'h1);
      @(posedge core_clk);
      chk({26'h0, routeCtl}, {26'h0, rows[i].route});
      apb(1'b0, A_ST, 32'h0);
      chk(rd, {24'h0, 1'b0, rows[i].div, rows[i].rt, rows[i].pll[1:0]});
      measure();
      chk(iv, {24'h0, rows[i].iv});
      pe = rows[i].route;
      $display("row %0d done", i);
    end
    calTry(1'b1, 32'h1);
    calTry(1'b1, 32'h0);
    calTry(1'b0, 32'h0);
    calTry(1'b1, 32'h1);
    $display("calibration test done");
    rstChk();
    pstrb <= 4'h0;
    apb(1'b1, A_PLL, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, A_PLL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, A_RT, 32'h1);
    apb(1'b1, A_UPD, 32'h2);
    @(posedge core_clk);
    chk({26'h0, routeCtl}, 32'h21);
    apb(1'b0, 12'h004, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, A_UPD, 32'h1);
    @(posedge core_clk);
    chk({26'h0, routeCtl}, 32'h20);
    measure();
    chk(iv, 32'h1);
    $display("refusal test done");
    print_verdict();
  end
endmodule
